// *** design/vrp_regs.svh ***
// shared constants of the voice recorder serial link
`ifndef VRP_REGS_SVH
`define VRP_REGS_SVH
`define VRP_BYTE_BITS 4'h8
`define VRP_DIR_WRITE 1'b0
`define VRP_DIR_READ 1'b1
`define VRP_DEF_SLAVE_ADDR 7'h40
`define VRP_IDLE_BYTE 8'hFF
`define VRP_FIFO_DEPTH 8
`define VRP_FIFO_WIDTH 8
`define VRP_CLK_NS 10
`define VRP_SCL_NS 5000
`define VRP_QTR_CYC ((`VRP_SCL_NS / 4) / `VRP_CLK_NS)
`define VRP_SEG_ADDR 3'h0
`define VRP_SEG_CMD 3'h1
`define VRP_SEG_AHI 3'h2
`define VRP_SEG_ALO 3'h3
`define VRP_SEG_RADDR 3'h4
`define VRP_SEG_RX 3'h5
`endif

// *** design/vrp_pkg.sv ***
// types shared by both ends of the voice recorder serial link
package vrp_pkg;
  typedef enum logic [2:0] {
    DS_IDLE, DS_ADDR, DS_RX, DS_ACK, DS_TX, DS_MACK
  } vrp_dev_state_type;
  typedef enum logic [2:0] {
    HS_IDLE, HS_START, HS_BIT, HS_RSTART, HS_STOP
  } vrp_host_state_type;
  typedef enum logic [1:0] {
    VRP_OP_STATUS, VRP_OP_ARRAY, VRP_OP_WRITE
  } vrp_op_type;
endpackage

// *** design/vrp_if.sv ***
// two-wire link between master and recorder, open-drain resolution
interface vrp_if;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;
  assign scl = ~(scl_m_oe & ~scl_m_o);
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
  modport dev (input scl, input sda, output sda_s_o, output sda_s_oe);
  modport host (input scl, input sda, output scl_m_o, output scl_m_oe,
                output sda_m_o, output sda_m_oe);
endinterface

// *** design/vrp_dev.sv ***
// recorder end: serial slave on the link clock, byte fetch on clk
//
// Behaviour
// - data changes only while clock low
// - master starts only on idle bus
// - start detected, new address byte begins
// - stop ends transaction, back to idle
// - eight bits then one acknowledge slot
// - no limit on bytes per transfer
// - slave acknowledges its own address and every received data byte low
// - master acks each read byte except last
// - on master nack, release data line
// - first byte: seven-bit address plus direction
// - direction zero means master writes
// - read without command returns status bytes
// - array read: command, two address bytes, read
`include "vrp_regs.svh"
module vrp_dev #(
  parameter logic [6:0] SLAVE_ADDR = `VRP_DEF_SLAVE_ADDR
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic link_clk,
  vrp_if.dev bus,
  output logic wr_valid,
  output logic [7:0] wr_cmd,
  output logic [15:0] wr_addr,
  output logic rd_req,
  output logic rd_array,
  output logic [15:0] rd_addr,
  input wire logic rd_ack,
  input wire logic [7:0] rd_data
);
  vrp_pkg::vrp_dev_state_type state_reg;
  logic scl_s1_reg, scl_s2_reg, scl_p_reg;
  logic sda_s1_reg, sda_s2_reg, sda_p_reg;
  logic [3:0] cnt_reg;
  logic [7:0] sh_reg;
  logic dir_reg, mack_ok_reg, sda_oe_reg;
  logic [1:0] wr_idx_reg;
  logic cmd_seen_reg;
  logic [7:0] cmd_reg;
  logic [15:0] arr_reg, ptr_reg, req_addr_reg;
  logic req_arr_reg, req_tgl_reg, wr_tgl_reg;
  logic [7:0] buf_reg;
  logic buf_v_reg;
  logic ack_s1_reg, ack_s2_reg, ack_p_reg;
  logic start_ev, stop_ev, rise_ev, fall_ev, byte_end;
  logic addr_hit, rd_hit, load_byte, rx_done;
  logic [7:0] tx_byte;
  // clk side
  logic req_s1_reg, req_s2_reg, req_p_reg;
  logic wrt_s1_reg, wrt_s2_reg, wrt_p_reg;
  logic ack_tgl_reg;
  logic [7:0] ack_data_reg;

  assign bus.sda_s_o = 1'b0;
  assign bus.sda_s_oe = sda_oe_reg;

  // link pins pass two flops before any edge logic looks at them
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_p_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_p_reg <= 1'b1;
    end else begin
      scl_s1_reg <= bus.scl;
      scl_s2_reg <= scl_s1_reg;
      scl_p_reg <= scl_s2_reg;
      sda_s1_reg <= bus.sda;
      sda_s2_reg <= sda_s1_reg;
      sda_p_reg <= sda_s2_reg;
    end
  end

  // data moving while clock is high is a control event, not a bit
  assign start_ev = scl_s2_reg & scl_p_reg & sda_p_reg & ~sda_s2_reg;
  assign stop_ev = scl_s2_reg & scl_p_reg & ~sda_p_reg & sda_s2_reg;
  assign rise_ev = scl_s2_reg & ~scl_p_reg;
  assign fall_ev = ~scl_s2_reg & scl_p_reg;
  assign byte_end = fall_ev && (cnt_reg == `VRP_BYTE_BITS);
  assign addr_hit = (state_reg == vrp_pkg::DS_ADDR) && byte_end &&
                    (sh_reg[7:1] == SLAVE_ADDR);
  assign rd_hit = addr_hit && (sh_reg[0] == `VRP_DIR_READ);
  assign rx_done = (state_reg == vrp_pkg::DS_RX) && byte_end;
  assign load_byte = fall_ev &&
    (((state_reg == vrp_pkg::DS_ACK) && (dir_reg == `VRP_DIR_READ)) ||
     ((state_reg == vrp_pkg::DS_MACK) && mack_ok_reg));
  // a late answer from the user side shows as an idle byte on the wire
  assign tx_byte = buf_v_reg ? buf_reg : `VRP_IDLE_BYTE;

  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= vrp_pkg::DS_IDLE;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      dir_reg <= `VRP_DIR_WRITE;
      mack_ok_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (start_ev) begin
      state_reg <= vrp_pkg::DS_ADDR;
      cnt_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
    end else if (stop_ev) begin
      state_reg <= vrp_pkg::DS_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      case (state_reg)
        vrp_pkg::DS_ADDR, vrp_pkg::DS_RX: begin
          if (rise_ev && cnt_reg != `VRP_BYTE_BITS) begin
            sh_reg <= {sh_reg[6:0], sda_s2_reg};
            cnt_reg <= cnt_reg + 4'h1;
          end
          if (byte_end) begin
            if (state_reg == vrp_pkg::DS_ADDR && !addr_hit) begin
              state_reg <= vrp_pkg::DS_IDLE;
            end else begin
              state_reg <= vrp_pkg::DS_ACK;
              sda_oe_reg <= 1'b1;
              if (state_reg == vrp_pkg::DS_ADDR) begin
                dir_reg <= sh_reg[0];
              end
            end
          end
        end
        vrp_pkg::DS_ACK: begin
          if (fall_ev) begin
            if (dir_reg == `VRP_DIR_READ) begin
              state_reg <= vrp_pkg::DS_TX;
              sh_reg <= {tx_byte[6:0], 1'b0};
              sda_oe_reg <= ~tx_byte[7];
              cnt_reg <= 4'h1;
            end else begin
              // write bytes keep coming until stop
              state_reg <= vrp_pkg::DS_RX;
              sda_oe_reg <= 1'b0;
              cnt_reg <= 4'h0;
            end
          end
        end
        vrp_pkg::DS_TX: begin
          if (fall_ev) begin
            if (cnt_reg != `VRP_BYTE_BITS) begin
              sda_oe_reg <= ~sh_reg[7];
              sh_reg <= {sh_reg[6:0], 1'b0};
              cnt_reg <= cnt_reg + 4'h1;
            end else begin
              state_reg <= vrp_pkg::DS_MACK;
              sda_oe_reg <= 1'b0;
            end
          end
        end
        vrp_pkg::DS_MACK: begin
          if (rise_ev) begin
            mack_ok_reg <= ~sda_s2_reg;
          end
          if (fall_ev) begin
            if (mack_ok_reg) begin
              state_reg <= vrp_pkg::DS_TX;
              sh_reg <= {tx_byte[6:0], 1'b0};
              sda_oe_reg <= ~tx_byte[7];
              cnt_reg <= 4'h1;
            end else begin
              state_reg <= vrp_pkg::DS_IDLE;
              sda_oe_reg <= 1'b0;
            end
          end
        end
        default: begin
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  // command and array address survive a repeated start, stop drops them
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      wr_idx_reg <= 2'h0;
      cmd_seen_reg <= 1'b0;
      cmd_reg <= 8'h00;
      arr_reg <= 16'h0000;
      wr_tgl_reg <= 1'b0;
    end else if (start_ev) begin
      wr_idx_reg <= 2'h0;
    end else if (stop_ev) begin
      cmd_seen_reg <= 1'b0;
    end else if (rx_done) begin
      case (wr_idx_reg)
        2'h0: cmd_reg <= sh_reg;
        2'h1: arr_reg[15:8] <= sh_reg;
        2'h2: begin
          arr_reg[7:0] <= sh_reg;
          cmd_seen_reg <= 1'b1;
          wr_tgl_reg <= ~wr_tgl_reg;
        end
        default: cmd_seen_reg <= cmd_seen_reg;
      endcase
      if (wr_idx_reg != 2'h3) begin
        wr_idx_reg <= wr_idx_reg + 2'h1;
      end
    end
  end

  // one byte is fetched ahead so it is ready before the next slot
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      ptr_reg <= 16'h0000;
      req_addr_reg <= 16'h0000;
      req_arr_reg <= 1'b0;
      req_tgl_reg <= 1'b0;
      buf_reg <= 8'h00;
      buf_v_reg <= 1'b0;
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
      ack_p_reg <= 1'b0;
    end else begin
      ack_s1_reg <= ack_tgl_reg;
      ack_s2_reg <= ack_s1_reg;
      ack_p_reg <= ack_s2_reg;
      if (rd_hit) begin
        req_arr_reg <= cmd_seen_reg;
        req_addr_reg <= cmd_seen_reg ? arr_reg : 16'h0000;
        ptr_reg <= (cmd_seen_reg ? arr_reg : 16'h0000) + 16'h0001;
        req_tgl_reg <= ~req_tgl_reg;
      end else if (load_byte) begin
        req_addr_reg <= ptr_reg;
        ptr_reg <= ptr_reg + 16'h0001;
        req_tgl_reg <= ~req_tgl_reg;
      end
      if (ack_s2_reg != ack_p_reg) begin
        buf_reg <= ack_data_reg;
        buf_v_reg <= 1'b1;
      end else if (rd_hit || load_byte) begin
        buf_v_reg <= 1'b0;
      end
    end
  end

  // user side: toggles crossing in, words are stable while they settle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      req_p_reg <= 1'b0;
      wrt_s1_reg <= 1'b0;
      wrt_s2_reg <= 1'b0;
      wrt_p_reg <= 1'b0;
      rd_req <= 1'b0;
      rd_array <= 1'b0;
      rd_addr <= 16'h0000;
      wr_valid <= 1'b0;
      wr_cmd <= 8'h00;
      wr_addr <= 16'h0000;
      ack_tgl_reg <= 1'b0;
      ack_data_reg <= 8'h00;
    end else if (ce) begin
      req_s1_reg <= req_tgl_reg;
      req_s2_reg <= req_s1_reg;
      req_p_reg <= req_s2_reg;
      wrt_s1_reg <= wr_tgl_reg;
      wrt_s2_reg <= wrt_s1_reg;
      wrt_p_reg <= wrt_s2_reg;
      rd_req <= req_s2_reg != req_p_reg;
      wr_valid <= wrt_s2_reg != wrt_p_reg;
      if (req_s2_reg != req_p_reg) begin
        rd_array <= req_arr_reg;
        rd_addr <= req_addr_reg;
      end
      if (wrt_s2_reg != wrt_p_reg) begin
        wr_cmd <= cmd_reg;
        wr_addr <= arr_reg;
      end
      if (rd_ack) begin
        ack_data_reg <= rd_data;
        ack_tgl_reg <= ~ack_tgl_reg;
      end
    end
  end
endmodule

// *** design/vrp_host.sv ***
// master end: byte fifo and two-wire sequencer on clk
`include "vrp_regs.svh"
module vrp_fifo #(
  parameter int W = `VRP_FIFO_WIDTH,
  parameter int D = `VRP_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_reg [D];
  logic [AW-1:0] wptr_reg, rptr_reg;
  logic [AW:0] cnt_reg;
  logic push, pop;
  assign in_ready = cnt_reg != (AW+1)'(D);
  assign out_valid = cnt_reg != '0;
  assign out_data = mem_reg[rptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem_reg[wptr_reg] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
    end else if (ce) begin
      if (push) begin
        wptr_reg <= (wptr_reg == AW'(D-1)) ? '0 : wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= (rptr_reg == AW'(D-1)) ? '0 : rptr_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module vrp_host #(
  parameter logic [6:0] SLAVE_ADDR = `VRP_DEF_SLAVE_ADDR
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  vrp_if.host bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire vrp_pkg::vrp_op_type cmd_op,
  input wire logic [7:0] cmd_cmd,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0] cmd_len,
  output logic done,
  output logic nack_err,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data
);
  localparam logic [8:0] QTR_LAST = 9'(`VRP_QTR_CYC - 1);
  vrp_pkg::vrp_host_state_type state_reg;
  vrp_pkg::vrp_op_type op_reg;
  logic [8:0] qcnt_reg;
  logic [1:0] ph_reg;
  logic [2:0] seg_reg;
  logic [3:0] bc_reg;
  logic [7:0] tx_reg, rx_reg, cmd_reg, len_reg;
  logic [15:0] addr_reg;
  logic scl_oe_reg, sda_oe_reg, nack_reg;
  logic sda_s1_reg, sda_s2_reg;
  logic tick, adv, fifo_ready, push, is_rx;

  assign bus.scl_m_o = 1'b0;
  assign bus.scl_m_oe = scl_oe_reg;
  assign bus.sda_m_o = 1'b0;
  assign bus.sda_m_oe = sda_oe_reg;
  assign is_rx = seg_reg == `VRP_SEG_RX;
  assign tick = qcnt_reg == QTR_LAST;
  // a full fifo holds the clock low before the next byte: real stall
  assign adv = tick && !(state_reg == vrp_pkg::HS_BIT && ph_reg == 2'h0 &&
               bc_reg == 4'h0 && is_rx && !fifo_ready);
  assign push = adv && state_reg == vrp_pkg::HS_BIT && ph_reg == 2'h3 &&
                bc_reg == `VRP_BYTE_BITS && is_rx;

  vrp_fifo #(.W(`VRP_FIFO_WIDTH), .D(`VRP_FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(rx_reg),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      qcnt_reg <= 9'h000;
    end else if (ce) begin
      sda_s1_reg <= bus.sda;
      sda_s2_reg <= sda_s1_reg;
      if (state_reg == vrp_pkg::HS_IDLE || tick) begin
        qcnt_reg <= 9'h000;
      end else begin
        qcnt_reg <= qcnt_reg + 9'h001;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= vrp_pkg::HS_IDLE;
      op_reg <= vrp_pkg::VRP_OP_STATUS;
      ph_reg <= 2'h0;
      seg_reg <= `VRP_SEG_ADDR;
      bc_reg <= 4'h0;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      cmd_reg <= 8'h00;
      len_reg <= 8'h00;
      addr_reg <= 16'h0000;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      nack_reg <= 1'b0;
      cmd_ready <= 1'b0;
      done <= 1'b0;
      nack_err <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      nack_err <= 1'b0;
      if (adv) begin
        ph_reg <= ph_reg + 2'h1;
      end
      case (state_reg)
        vrp_pkg::HS_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            op_reg <= cmd_op;
            cmd_reg <= cmd_cmd;
            addr_reg <= cmd_addr;
            len_reg <= (cmd_len == 8'h00) ? 8'h01 : cmd_len;
            ph_reg <= 2'h0;
            state_reg <= vrp_pkg::HS_START;
          end else begin
            cmd_ready <= sda_s2_reg;
          end
        end
        vrp_pkg::HS_START: begin
          if (adv && ph_reg == 2'h0) begin
            sda_oe_reg <= 1'b1;
          end else if (adv && ph_reg == 2'h1) begin
            scl_oe_reg <= 1'b1;
            state_reg <= vrp_pkg::HS_BIT;
            ph_reg <= 2'h0;
            seg_reg <= `VRP_SEG_ADDR;
            bc_reg <= 4'h0;
            tx_reg <= {SLAVE_ADDR, (op_reg == vrp_pkg::VRP_OP_STATUS) ?
                       `VRP_DIR_READ : `VRP_DIR_WRITE};
          end
        end
        vrp_pkg::HS_BIT: begin
          if (adv) begin
            case (ph_reg)
              2'h0: begin
                // data moves only while the clock is low
                if (bc_reg != `VRP_BYTE_BITS) begin
                  sda_oe_reg <= !is_rx && !tx_reg[7];
                end else begin
                  sda_oe_reg <= is_rx && len_reg != 8'h01;
                end
              end
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: begin
                if (bc_reg != `VRP_BYTE_BITS) begin
                  rx_reg <= {rx_reg[6:0], sda_s2_reg};
                  tx_reg <= {tx_reg[6:0], 1'b0};
                end else begin
                  nack_reg <= sda_s2_reg;
                end
              end
              default: begin
                scl_oe_reg <= 1'b1;
                if (bc_reg != `VRP_BYTE_BITS) begin
                  bc_reg <= bc_reg + 4'h1;
                end else begin
                  bc_reg <= 4'h0;
                  if (is_rx) begin
                    len_reg <= len_reg - 8'h01;
                    if (len_reg == 8'h01) begin
                      state_reg <= vrp_pkg::HS_STOP;
                    end
                  end else if (nack_reg) begin
                    nack_err <= 1'b1;
                    state_reg <= vrp_pkg::HS_STOP;
                  end else begin
                    case (seg_reg)
                      `VRP_SEG_ADDR: begin
                        if (op_reg == vrp_pkg::VRP_OP_STATUS) begin
                          seg_reg <= `VRP_SEG_RX;
                        end else begin
                          seg_reg <= `VRP_SEG_CMD;
                          tx_reg <= cmd_reg;
                        end
                      end
                      `VRP_SEG_CMD: begin
                        seg_reg <= `VRP_SEG_AHI;
                        tx_reg <= addr_reg[15:8];
                      end
                      `VRP_SEG_AHI: begin
                        seg_reg <= `VRP_SEG_ALO;
                        tx_reg <= addr_reg[7:0];
                      end
                      `VRP_SEG_ALO: begin
                        if (op_reg == vrp_pkg::VRP_OP_ARRAY) begin
                          state_reg <= vrp_pkg::HS_RSTART;
                        end else begin
                          state_reg <= vrp_pkg::HS_STOP;
                        end
                      end
                      default: seg_reg <= `VRP_SEG_RX;
                    endcase
                  end
                end
              end
            endcase
          end
        end
        vrp_pkg::HS_RSTART: begin
          if (adv) begin
            case (ph_reg)
              2'h0: sda_oe_reg <= 1'b0;
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: sda_oe_reg <= 1'b1;
              default: begin
                scl_oe_reg <= 1'b1;
                state_reg <= vrp_pkg::HS_BIT;
                seg_reg <= `VRP_SEG_RADDR;
                tx_reg <= {SLAVE_ADDR, `VRP_DIR_READ};
              end
            endcase
          end
        end
        vrp_pkg::HS_STOP: begin
          if (adv) begin
            case (ph_reg)
              2'h0: sda_oe_reg <= 1'b1;
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: sda_oe_reg <= 1'b0;
              default: begin
                state_reg <= vrp_pkg::HS_IDLE;
                done <= 1'b1;
              end
            endcase
          end
        end
        default: state_reg <= vrp_pkg::HS_IDLE;
      endcase
    end
  end
endmodule

// *** verification/vrp_link_monitor.sv ***
// checker for the two-wire link between the host and recorder ends
module vrp_link_monitor (
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_reg, sda_reg, first_reg, dir_reg, start, stop, rise;
  logic nack_seen_reg;
  logic [3:0] bit_reg;
  assign start = scl & scl_reg & sda_reg & ~sda;
  assign stop = scl & scl_reg & ~sda_reg & sda;
  assign rise = scl & ~scl_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else begin
      scl_reg <= scl;
      sda_reg <= sda;
    end
  end
  // bit slot before this rise; a repeated start restarts the frame
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bit_reg <= 4'h0;
      first_reg <= 1'b1;
      dir_reg <= 1'b0;
      nack_seen_reg <= 1'b0;
    end else if (start) begin
      bit_reg <= 4'h0;
      first_reg <= 1'b1;
      nack_seen_reg <= 1'b0;
    end else if (rise) begin
      bit_reg <= (bit_reg == 4'h8) ? 4'h0 : bit_reg + 4'h1;
      // master nack on a read: the slave must stay off the line until start
      if (bit_reg == 4'h8 && !first_reg && dir_reg && sda) begin
        nack_seen_reg <= 1'b1;
      end
      if (bit_reg == 4'h8) first_reg <= 1'b0;
      if (bit_reg == 4'h7 && first_reg) dir_reg <= sda;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_hold; scl && scl_reg |-> $stable(sda_s_oe); endproperty
  property p_start; start |-> ##[1:300] !scl; endproperty
  property p_stop; stop |-> ##1 (scl && sda) [*8]; endproperty
  property p_frame; stop |-> bit_reg == 4'h1; endproperty
  property p_ack;
    rise && bit_reg == 4'h8 && (first_reg || !dir_reg) |-> !sda && sda_s_oe;
  endproperty
  property p_mack;
    rise && bit_reg == 4'h8 && !first_reg && dir_reg |-> !sda_s_oe;
  endproperty
  property p_release; nack_seen_reg |-> !sda_s_oe; endproperty
  property p_addr; rise && first_reg && bit_reg < 4'h8 |-> !sda_s_oe;
  endproperty
  property p_wr;
    rise && !first_reg && !dir_reg && bit_reg < 4'h8 |-> !sda_s_oe;
  endproperty
  property p_rd;
    rise && !first_reg && dir_reg && bit_reg < 4'h8 && !nack_seen_reg
      |-> !sda_m_oe;
  endproperty
  a_hold: assert property (p_hold) else $error("data moved, clock high");
  a_start: assert property (p_start) else $error("no clock after start");
  a_stop: assert property (p_stop) else $error("bus not idle after stop");
  a_frame: assert property (p_frame) else $error("stop inside a byte");
  a_ack: assert property (p_ack) else $error("received byte not acked");
  a_mack: assert property (p_mack) else $error("slave drove master ack");
  a_release: assert property (p_release) else $error("no release");
  a_addr: assert property (p_addr) else $error("slave drove address");
  a_wr: assert property (p_wr) else $error("slave drove write data");
  a_rd: assert property (p_rd) else $error("master drove read data");
  c_start: cover property (start);
  c_stop: cover property (stop);
  c_nack: cover property (rise && bit_reg == 4'h8 && dir_reg && sda);
  c_wr_ack: cover property (rise && bit_reg == 4'h8 && !first_reg && !dir_reg);
endmodule

// *** verification/voice_recorder_i2c_slave_port_test.sv ***
// end-to-end bench: host and recorder ends joined over the link
module voice_recorder_i2c_slave_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0;
  logic rd_ready = 1'b1;
  vrp_pkg::vrp_op_type cmd_op = vrp_pkg::VRP_OP_STATUS;
  logic [7:0] cmd_cmd = 8'h00;
  logic [15:0] cmd_addr = 16'h0000;
  logic [7:0] cmd_len = 8'h00;
  logic cmd_ready, done, nack_err, rd_valid, wr_valid, rd_req, rd_array;
  logic [7:0] got_data, wr_cmd, wcmd_seen;
  logic [15:0] wr_addr, rd_addr, waddr_seen;
  logic dev_ack = 1'b0;
  logic [7:0] dev_data = 8'h00;
  logic [7:0] got[$];
  int n_errors = 0;
  int tests_run = 0;
  int n_wr = 0;
  int n_nack = 0;
  int cycles = 0;
  vrp_if link_bus ();
  vrp_host vrp_host_inst (.clk(clk), .resetn(resetn), .ce(1'b1),
    .bus(link_bus), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_cmd(cmd_cmd), .cmd_addr(cmd_addr),
    .cmd_len(cmd_len), .done(done), .nack_err(nack_err),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(got_data));
  vrp_dev vrp_dev_inst (.clk(clk), .resetn(resetn), .ce(1'b1),
    .link_clk(link_clk), .bus(link_bus), .wr_valid(wr_valid),
    .wr_cmd(wr_cmd), .wr_addr(wr_addr), .rd_req(rd_req),
    .rd_array(rd_array), .rd_addr(rd_addr), .rd_ack(dev_ack),
    .rd_data(dev_data));
  vrp_link_monitor vrp_link_monitor_inst (.clk(clk), .resetn(resetn),
    .scl(link_bus.scl), .sda(link_bus.sda), .sda_m_oe(link_bus.sda_m_oe),
    .sda_s_oe(link_bus.sda_s_oe));
  always #5 clk = ~clk;
  // phase offset keeps the link clock edges off the user clock edges
  initial begin
    #33;
    forever #80 link_clk = ~link_clk;
  end
  // storage side: status bytes count up, array bytes are address based
  always @(posedge clk) begin
    dev_ack <= rd_req;
    dev_data <= rd_array ? (rd_addr[7:0] ^ 8'h5A) : (8'hA0 + rd_addr[7:0]);
  end
  always @(posedge clk) begin
    if (rd_valid && rd_ready) got.push_back(got_data);
    if (nack_err === 1'b1) n_nack++;
    if (wr_valid === 1'b1) begin
      n_wr++;
      wcmd_seen <= wr_cmd;
      waddr_seen <= wr_addr;
    end
  end
  // ceiling sized for a status read, an array read and a plain write
  always @(posedge clk) begin
    cycles++;
    if (cycles == 100000) begin
      n_errors++;
      $display("ERROR run timed out");
      tally_and_finish();
    end
  end
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] seen);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic run(input vrp_pkg::vrp_op_type op, input logic [7:0] c,
                     input logic [15:0] a, input logic [7:0] n);
    got.delete();
    n_nack = 0;
    n_wr = 0;
    while (cmd_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    cmd_op <= op;
    cmd_cmd <= c;
    cmd_addr <= a;
    cmd_len <= n;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    while (done !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    repeat (4) @(posedge clk);
    check("idle bus", 16'h0003, {link_bus.scl, link_bus.sda});
    check("slave nacks", 16'h0, 16'(n_nack));
  endtask
  task automatic test_status;
    run(vrp_pkg::VRP_OP_STATUS, 8'h00, 16'h0000, 8'h02);
    check("status count", 16'h2, 16'(got.size()));
    check("status byte 0", 16'h00A0, {8'h00, got[0]});
    check("status byte 1", 16'h00A1, {8'h00, got[1]});
    check("status writes", 16'h0, 16'(n_wr));
    $display("status read test finished");
  endtask
  task automatic test_array;
    run(vrp_pkg::VRP_OP_ARRAY, 8'hC3, 16'h1234, 8'h01);
    check("array writes", 16'h1, 16'(n_wr));
    check("command byte", 16'h00C3, {8'h00, wcmd_seen});
    check("array address", 16'h1234, waddr_seen);
    check("array count", 16'h1, 16'(got.size()));
    check("array byte", 16'h006E, {8'h00, got[0]});
    $display("array read test finished");
  endtask
  // write only: command and address land, nothing is read back
  task automatic test_write;
    run(vrp_pkg::VRP_OP_WRITE, 8'h5C, 16'hBEEF, 8'h00);
    check("write writes", 16'h1, 16'(n_wr));
    check("write command", 16'h005C, {8'h00, wcmd_seen});
    check("write address", 16'hBEEF, waddr_seen);
    check("write reads", 16'h0, 16'(got.size()));
    $display("plain write test finished");
  endtask
  task automatic test_reset;
    check("idle after reset", 16'h0003, {link_bus.scl, link_bus.sda});
    $display("reset test finished");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
    test_reset();
    test_status();
    test_array();
    test_write();
    tally_and_finish();
  end
endmodule
